//--- fcp_pkg.sv
package fcp_pkg;
    // fuse high byte bit positions
    localparam int HI_DEBUG_BIT = 7;
    localparam int HI_SCAN_BIT = 6;
    localparam int HI_SERIAL_BIT = 5;
    localparam int HI_WDOG_BIT = 4;
    localparam int HI_EERET_BIT = 3;
    localparam int HI_BOOT_MSB = 2;
    localparam int HI_BOOT_LSB = 1;
    localparam int HI_RSTVEC_BIT = 0;
    // fuse low byte bit positions
    localparam int LO_DIV8_BIT = 7;
    localparam int LO_CLOCK_PIN_OUTPUT_FUSE_BIT = 6;
    localparam int LO_SUT_MSB = 5;
    localparam int LO_SUT_LSB = 4;
    localparam int LO_CKSEL_MSB = 3;
    localparam int LO_CKSEL_LSB = 0;
    // reset values, 0 means programmed
    localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
    localparam logic [7:0] FUSE_LOW_RST = 8'h62;
    // action select codes {action_select_1, action_select_0}
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    // command bytes
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    // byte select {byte_select_hi, byte_select_lo}
    localparam logic [1:0] BSEL_LOW = 2'h0;
    localparam logic [1:0] BSEL_HIGH = 2'h1;
    localparam logic [1:0] BSEL_EXT = 2'h2;
    localparam logic [1:0] BSEL_FHIGH = 2'h3;
    // memory geometry
    localparam int FLASH_WORD_BITS = 7;
    localparam int FLASH_PAGE_BITS = 9;
    localparam int EE_BYTE_BITS = 3;
    localparam int EE_PAGE_BITS = 9;
    // busy time of a programming operation, cycles
    localparam int BUSY_CYCLES = 16;
    localparam logic [7:0] EXT_FUSE_RST = 8'hFE;
    localparam logic [7:0] LOCK_RST = 8'hFF;

    typedef struct packed {
        logic debug_enable;
        logic boundary_scan_port_enable;
        logic serial_download_enable;
        logic watchdog_forced_on;
        logic eeprom_retain;
        logic [1:0] boot_area_size;
        logic reset_vector_select;
        logic clock_div_eight;
        logic clock_pin_output;
        logic [1:0] startup_delay_select;
        logic [3:0] clock_source_select;
    } fcp_settings_type;

    typedef struct packed {
        logic action_select_1;
        logic action_select_0;
        logic byte_select_hi;
        logic byte_select_lo;
        logic page_load_strobe;
        logic wr_n;
        logic oe_n;
    } fcp_pins_type;
endpackage

//--- fcp_decode.sv
module fcp_decode
    import fcp_pkg::*;
(
    // fuse bytes
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] fuse_low,
    // decoded settings, active high
    output fcp_pkg::fcp_settings_type settings
);
    // a programmed fuse reads 0, so single-bit enables invert
    assign settings.debug_enable = ~fuse_high[HI_DEBUG_BIT];
    assign settings.boundary_scan_port_enable =
        ~fuse_high[HI_SCAN_BIT];
    assign settings.serial_download_enable =
        ~fuse_high[HI_SERIAL_BIT];
    assign settings.watchdog_forced_on = ~fuse_high[HI_WDOG_BIT];
    assign settings.eeprom_retain = ~fuse_high[HI_EERET_BIT];
    assign settings.boot_area_size =
        fuse_high[HI_BOOT_MSB:HI_BOOT_LSB];
    assign settings.reset_vector_select = fuse_high[HI_RSTVEC_BIT];
    assign settings.clock_div_eight = ~fuse_low[LO_DIV8_BIT];
    assign settings.clock_pin_output = ~fuse_low[LO_CLOCK_PIN_OUTPUT_FUSE_BIT];
    assign settings.startup_delay_select =
        fuse_low[LO_SUT_MSB:LO_SUT_LSB];
    assign settings.clock_source_select =
        fuse_low[LO_CKSEL_MSB:LO_CKSEL_LSB];
endmodule

//--- fcp_top.sv
// Function
// - high fuse bit 7 programmed enables debug, clocks run in sleep.
// - high fuse bit 6 enables boundary-scan port, programmed by default.
// - high fuse bit 5 enables serial download; locked in serial mode.
// - high fuse bit 4 programmed forces the watchdog on.
// - high fuse bit 3 programmed keeps EEPROM through chip erase.
// - high bits 2:1 boot size default programmed; bit 0 reset vector.
// - low bits 3:0 clock source default RC 8 MHz; bit 7 divides by 8.
// - low fuse bit 6 programmed outputs system clock on a pin.
// - low bits 5:4 start-up delay, default longest.
// - chip erase leaves all fuse bits unchanged.
// - fuse writes refused once lock bit one is programmed.
// - fuses latched on programming entry; changes apply after exit.
// - EEPROM-retain fuse takes effect at once when programmed.
// - fuses also latched at power-up in normal mode.
// - three signature bytes readable in programming mode, even when locked.
// - calibration byte at signature 0x000 high copied to trim at reset.
// - flash 512 pages of 128 words; PC 6:0 word, 15:7 page.
// - EEPROM 512 pages of 8 bytes; address 2:0 byte, 11:3 page.
// - action selects sampled at programming clock rise decide latch.
// - low pulse on write strobe or output enable runs loaded command.
// - ready/busy low while operation runs, high when ready.
// - data bus driven only while output enable is low.
// - programmed fuse reads 0, unprogrammed reads 1.
// - command byte codes for erase, writes and reads.
// - byte selects 00 low, 01 high/lock, 10 extended, 11 fuse high.
module fcp_top
    import fcp_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h3C, // arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h69, // arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80,
    parameter int BUSY_LEN = BUSY_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // mode
    input wire logic prog_mode,
    input wire logic serial_mode,
    // programming pins
    input wire logic programming_clock_in,
    input wire fcp_pkg::fcp_pins_type pins,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready_busy_out,
    // device settings and status
    output fcp_pkg::fcp_settings_type settings,
    output logic [7:0] rc_trim_register,
    output logic eeprom_retain_now,
    output logic [FLASH_PAGE_BITS-1:0] page_index,
    output logic [FLASH_WORD_BITS-1:0] word_in_page_index,
    output logic [EE_PAGE_BITS-1:0] eeprom_page,
    output logic [EE_BYTE_BITS-1:0] eeprom_byte,
    output logic erase_eeprom_pulse
);
    import fcp_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} fcp_state_type;

    logic [7:0] fuse_config_high_r, fuse_config_high_nxt;
    logic [7:0] fuse_config_low_r, fuse_config_low_nxt;
    logic [7:0] fuse_ext_r;
    logic [7:0] lock_r, lock_nxt;
    logic [7:0] act_high_r, act_low_r;
    logic [7:0] cmd_r, addr_lo_r, addr_hi_r, data_r;
    logic [7:0] data_out_r, trim_r;
    logic data_oe_r, rdy_r, clk_d_r, wr_d_r, oe_d_r, prog_d_r;
    logic init_r, eeret_r, erase_ee_r;
    logic [15:0] busy_cnt_r;
    fcp_state_type state_r, state_nxt;
    fcp_settings_type settings_r, dec_w;

    wire clk_rise = programming_clock_in & ~clk_d_r;
    wire wr_fall = ~pins.wr_n & wr_d_r;
    wire oe_fall = ~pins.oe_n & oe_d_r;
    wire [1:0] act = {pins.action_select_1, pins.action_select_0};
    wire [1:0] bsel = {pins.byte_select_hi, pins.byte_select_lo};
    wire lock_one_prog = ~lock_r[0];
    wire idle = (state_r == ST_IDLE);
    wire start_wr = prog_mode & wr_fall & idle;
    wire do_wr_fuse = start_wr & (cmd_r == CMD_WR_FUSE)
                      & ~lock_one_prog;
    wire do_erase = start_wr & (cmd_r == CMD_CHIP_ERASE);
    wire do_wr_lock = start_wr & (cmd_r == CMD_WR_LOCK);
    wire wr_fuse_high = do_wr_fuse & (bsel == BSEL_HIGH);
    wire wr_fuse_low = do_wr_fuse & (bsel == BSEL_LOW);
    wire start_busy = do_erase | do_wr_fuse | do_wr_lock
                      | (start_wr & ((cmd_r == CMD_WR_FLASH)
                      | (cmd_r == CMD_WR_EEPROM)));
    wire prog_entry = prog_mode & ~prog_d_r;
    wire prog_exit = ~prog_mode & prog_d_r;
    wire latch_fuses = prog_entry | prog_exit | init_r;
    // serial-download bit is held while in serial mode
    wire [7:0] hi_wmask = serial_mode ?
        ~(8'h01 << HI_SERIAL_BIT) : 8'hFF;

    // high fuse writes are masked in serial mode, chip erase never touches fuse bits
    // written value is the loaded data byte, not the live bus
    assign fuse_config_high_nxt = wr_fuse_high ?
        ((data_r & hi_wmask) | (fuse_config_high_r & ~hi_wmask)) :
        fuse_config_high_r;
    assign fuse_config_low_nxt = wr_fuse_low ? data_r :
        fuse_config_low_r;
    // lock bits can only be programmed, erase restores them
    assign lock_nxt = do_erase ? LOCK_RST :
        (do_wr_lock ? (lock_r & data_r) : lock_r);
    assign state_nxt = start_busy ? ST_BUSY :
        ((state_r == ST_BUSY && busy_cnt_r == 16'h0000) ? ST_IDLE :
        state_r);

    // read mux for output enable
    wire [7:0] sig_sel = (addr_lo_r[1:0] == 2'h0) ? SIG_BYTE0 :
        (addr_lo_r[1:0] == 2'h1) ? SIG_BYTE1 : SIG_BYTE2;
    wire [7:0] sig_rd = pins.byte_select_lo ? CAL_BYTE : sig_sel;
    wire [7:0] fuse_rd = (bsel == BSEL_LOW) ? fuse_config_low_r :
        (bsel == BSEL_HIGH) ? lock_r :
        (bsel == BSEL_EXT) ? fuse_ext_r : fuse_config_high_r;
    // signature read has no lock check on purpose
    wire [7:0] rd_val = (cmd_r == CMD_RD_SIG) ? sig_rd :
        (cmd_r == CMD_RD_FUSE) ? fuse_rd : 8'hFF;

    fcp_decode u_dec (
        .fuse_high(act_high_r),
        .fuse_low(act_low_r),
        .settings(dec_w)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_d_r <= 1'b0;
            wr_d_r <= 1'b1;
            oe_d_r <= 1'b1;
            prog_d_r <= 1'b0;
            init_r <= 1'b1;
        end else begin
            clk_d_r <= programming_clock_in;
            wr_d_r <= pins.wr_n;
            oe_d_r <= pins.oe_n;
            prog_d_r <= prog_mode;
            init_r <= 1'b0;
        end
    end

    // nonvolatile store; only power-on reset would matter, rst models it
    always_ff @(posedge clk) begin
        if (rst) begin
            fuse_config_high_r <= FUSE_HIGH_RST;
            fuse_config_low_r <= FUSE_LOW_RST;
            fuse_ext_r <= EXT_FUSE_RST;
            lock_r <= LOCK_RST;
        end else begin
            fuse_config_high_r <= fuse_config_high_nxt;
            fuse_config_low_r <= fuse_config_low_nxt;
            lock_r <= lock_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            act_high_r <= FUSE_HIGH_RST;
            act_low_r <= FUSE_LOW_RST;
        end else if (latch_fuses) begin
            act_high_r <= fuse_config_high_r;
            act_low_r <= fuse_config_low_r;
        end
    end

    // retain bit bypasses the latch
    always_ff @(posedge clk) begin
        if (rst) begin
            eeret_r <= ~FUSE_HIGH_RST[HI_EERET_BIT];
        end else begin
            eeret_r <= ~fuse_config_high_nxt[HI_EERET_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            erase_ee_r <= 1'b0;
        end else begin
            erase_ee_r <= do_erase & ~eeret_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r <= 8'h00;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            data_r <= 8'h00;
        end else if (prog_mode && clk_rise) begin
            case (act)
                ACT_ADDR: begin
                    if (bsel == BSEL_LOW) begin
                        addr_lo_r <= data_in;
                    end else if (bsel == BSEL_HIGH) begin
                        addr_hi_r <= data_in;
                    end
                end
                ACT_DATA: data_r <= data_in;
                ACT_CMD: cmd_r <= data_in;
                ACT_IDLE: cmd_r <= cmd_r;
                default: cmd_r <= cmd_r;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            busy_cnt_r <= 16'h0000;
            rdy_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (start_busy) begin
                busy_cnt_r <= 16'(BUSY_LEN - 1);
            end else if (busy_cnt_r != 16'h0000) begin
                busy_cnt_r <= busy_cnt_r - 16'h0001;
            end
            rdy_r <= (state_nxt == ST_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_oe_r <= 1'b0;
            data_out_r <= 8'h00;
        end else begin
            data_oe_r <= prog_mode & ~pins.oe_n;
            if (oe_fall) begin
                data_out_r <= rd_val;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trim_r <= CAL_BYTE;
            settings_r <= '0;
        end else begin
            trim_r <= trim_r;
            settings_r <= dec_w;
        end
    end

    AST_BUSY_LOW: assert property (@(posedge clk) disable iff (rst)
        start_busy |=> !ready_busy_out [*2])
        else $error("ready not low after operation start");
    AST_ERASE_KEEPS_FUSE: assert property (@(posedge clk) disable iff (rst)
        do_erase |=> (fuse_config_high_r == $past(fuse_config_high_r)))
        else $error("chip erase changed fuses");
    AST_LOCK_REFUSE: assert property (@(posedge clk) disable iff (rst)
        (lock_one_prog && !latch_fuses) |=>
        $stable(fuse_config_low_r))
        else $error("fuse written while locked");
    AST_NO_DRIVE: assert property (@(posedge clk) disable iff (rst)
        pins.oe_n |=> !data_oe)
        else $error("bus driven with output enable high");
    AST_HOLD_IN_PROG: assert property (@(posedge clk) disable iff (rst)
        (prog_mode && $past(prog_mode) && !init_r) |=>
        $stable(act_high_r))
        else $error("active fuses changed in programming mode");
    AST_EERET_NOW: assert property (@(posedge clk) disable iff (rst)
        wr_fuse_high && !data_r[HI_EERET_BIT] |=> eeprom_retain_now)
        else $error("retain fuse not immediate");
    AST_SERIAL_HOLD: assert property (@(posedge clk) disable iff (rst)
        serial_mode |=> fuse_config_high_r[HI_SERIAL_BIT] ==
        $past(fuse_config_high_r[HI_SERIAL_BIT]))
        else $error("serial fuse changed in serial mode");
    AST_CMD_LATCH: assert property (@(posedge clk) disable iff (rst)
        prog_mode && clk_rise && act == ACT_CMD |=> cmd_r == $past(data_in))
        else $error("command not latched");

    assign data_out = data_out_r;
    assign data_oe = data_oe_r;
    assign ready_busy_out = rdy_r;
    assign settings = settings_r;
    assign rc_trim_register = trim_r;
    assign eeprom_retain_now = eeret_r;
    assign erase_eeprom_pulse = erase_ee_r;
    // flash address {addr_hi, addr_lo}: word low, page high
    assign word_in_page_index = addr_lo_r[FLASH_WORD_BITS-1:0];
    assign page_index = {addr_hi_r, addr_lo_r[7]};
    assign eeprom_byte = addr_lo_r[EE_BYTE_BITS-1:0];
    assign eeprom_page = {addr_hi_r[3:0], addr_lo_r[7:3]};
endmodule

//--- fcp_prog_model.sv
module fcp_prog_model
    import fcp_pkg::*;
(
    // clock and device answers
    input wire logic clk,
    input wire logic ready_busy_out,
    input wire logic data_oe,
    input wire logic [7:0] data_out,
    // programmer drives
    output logic programming_clock_in,
    output fcp_pkg::fcp_pins_type pins,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        programming_clock_in = 1'b0;
        pins = 7'h63;
        data_in = 8'h00;
    end
    // selects and data settle a cycle before the clock pulse
    task automatic load(input logic [1:0] act, input logic [1:0] bsel,
                        input logic [7:0] d);
        @(posedge clk);
        {pins.action_select_1, pins.action_select_0} <= act;
        {pins.byte_select_hi, pins.byte_select_lo} <= bsel;
        data_in <= d;
        @(posedge clk);
        programming_clock_in <= 1'b1;
        @(posedge clk);
        programming_clock_in <= 1'b0;
        @(posedge clk);
        {pins.action_select_1, pins.action_select_0} <= ACT_IDLE;
    endtask
    // command is always loaded by the caller first
    task automatic write(input logic [1:0] bsel, output logic busy,
                         output logic done);
        @(posedge clk);
        {pins.byte_select_hi, pins.byte_select_lo} <= bsel;
        pins.wr_n <= 1'b0;
        @(posedge clk);
        pins.wr_n <= 1'b1;
        #1 busy = (ready_busy_out === 1'b0);
        done = 1'b0;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge clk);
            #1 done = (ready_busy_out === 1'b1);
        end
    endtask
    // bus released while output enable is low: show the inverse
    task automatic read(input logic [1:0] bsel, output logic [7:0] v,
                        output logic oe);
        @(posedge clk);
        {pins.byte_select_hi, pins.byte_select_lo} <= bsel;
        pins.oe_n <= 1'b0;
        data_in <= ~data_in;
        repeat (2) @(posedge clk);
        #1 v = data_out;
        oe = data_oe;
        @(posedge clk);
        pins.oe_n <= 1'b1;
    endtask
endmodule

//--- fcp_top_tb.sv
module fcp_top_tb import fcp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SIG0 = 8'hC3; // arbitrary value
    localparam logic [7:0] SIG1 = 8'h5E; // arbitrary value
    localparam logic [7:0] SIG2 = 8'h17; // arbitrary value
    localparam logic [7:0] CAL = 8'h4D;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic prog_mode = 1'b0;
    logic serial_mode = 1'b0;
    logic programming_clock_in, data_oe, ready_busy_out, eeprom_retain_now;
    logic erase_eeprom_pulse;
    fcp_pins_type pins;
    fcp_settings_type settings;
    logic [7:0] data_in, data_out, rc_trim_register;
    logic [8:0] page_index, eeprom_page;
    logic [6:0] word_in_page_index;
    logic [2:0] eeprom_byte;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int erase_cnt = 0;
    always #10 clk = ~clk;
    fcp_top #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
        .CAL_BYTE(CAL), .BUSY_LEN(4)) DUT (.clk(clk), .rst(rst),
        .prog_mode(prog_mode), .serial_mode(serial_mode),
        .programming_clock_in(programming_clock_in), .pins(pins),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ready_busy_out(ready_busy_out), .settings(settings),
        .rc_trim_register(rc_trim_register),
        .eeprom_retain_now(eeprom_retain_now), .page_index(page_index),
        .word_in_page_index(word_in_page_index), .eeprom_page(eeprom_page),
        .eeprom_byte(eeprom_byte), .erase_eeprom_pulse(erase_eeprom_pulse));
    fcp_prog_model prog (.clk(clk), .ready_busy_out(ready_busy_out),
        .data_oe(data_oe), .data_out(data_out),
        .programming_clock_in(programming_clock_in), .pins(pins),
        .data_in(data_in));
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (erase_eeprom_pulse === 1'b1)
            erase_cnt <= erase_cnt + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // settings are active high; fuse bits read 0 when programmed
    function automatic logic [15:0] exp_set(input logic [7:0] hi, lo);
        return {~hi[7], ~hi[6], ~hi[5], ~hi[4], ~hi[3], hi[2:1], hi[0],
                ~lo[7], ~lo[6], lo[5:4], lo[3:0]};
    endfunction
    task automatic wr_op(input logic [7:0] cmd, input logic [1:0] bsel,
                         input logic [7:0] d, output logic busy);
        logic done;
        prog.load(ACT_CMD, BSEL_LOW, cmd);
        prog.load(ACT_DATA, bsel, d);
        prog.write(bsel, busy, done);
        check("ready", 16'(done), 16'h1);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] cmd,
                          input logic [1:0] bsel, input logic [7:0] exp);
        logic [7:0] v;
        logic oe;
        prog.load(ACT_CMD, BSEL_LOW, cmd);
        prog.read(bsel, v, oe);
        check("bus drive", 16'(oe), 16'h1);
        check(name, 16'(v), 16'(exp));
    endtask
    task automatic t_defaults();
        logic [15:0] e;
        e = exp_set(FUSE_HIGH_RST, FUSE_LOW_RST);
        check("set", 16'(settings), e);
        check("set", 16'(settings), e);
        check("trim", 16'(rc_trim_register), 16'(CAL));
        check("ready idle", 16'(ready_busy_out), 16'h1);
        check("bus idle", 16'(data_oe), 16'h0);
    endtask
    task automatic t_reads();
        rd_chk("fuse low", CMD_RD_FUSE, BSEL_LOW, FUSE_LOW_RST);
        rd_chk("fuse high", CMD_RD_FUSE, BSEL_FHIGH, FUSE_HIGH_RST);
        rd_chk("lock", CMD_RD_FUSE, BSEL_HIGH, LOCK_RST);
        rd_chk("fuse ext", CMD_RD_FUSE, BSEL_EXT, EXT_FUSE_RST);
    endtask
    task automatic t_signature();
        logic [7:0] sig [3];
        sig = '{SIG0, SIG1, SIG2};
        for (int i = 0; i < 3; i++) begin
            prog.load(ACT_ADDR, BSEL_LOW, 8'(i));
            rd_chk("signature", CMD_RD_SIG, BSEL_LOW, sig[i]);
        end
        prog.load(ACT_ADDR, BSEL_LOW, 8'h00);
        rd_chk("calibration", CMD_RD_SIG, BSEL_HIGH, CAL);
    endtask
    task automatic t_address();
        prog.load(ACT_ADDR, BSEL_LOW, 8'hAB);
        prog.load(ACT_ADDR, BSEL_HIGH, 8'hCD);
        check("page", 16'(page_index), 16'h019B);
        check("word", 16'(word_in_page_index), 16'h002B);
        check("ee page", 16'(eeprom_page), 16'h01B5);
        check("ee byte", 16'(eeprom_byte), 16'h0003);
    endtask
    // erase with retention unprogrammed clears the eeprom, fuses stay
    task automatic t_erase_fuses();
        logic busy;
        int n;
        logic [15:0] e;
        e = exp_set(FUSE_HIGH_RST, FUSE_LOW_RST);
        n = erase_cnt;
        wr_op(CMD_CHIP_ERASE, BSEL_LOW, 8'hFF, busy);
        check("erase pulses", 16'(erase_cnt - n), 16'h1);
        rd_chk("fuse low", CMD_RD_FUSE, BSEL_LOW, FUSE_LOW_RST);
        wr_op(CMD_WR_FUSE, BSEL_LOW, 8'hE2, busy);
        check("busy", 16'(busy), 16'h1);
        wr_op(CMD_WR_FUSE, BSEL_HIGH, 8'h91, busy);
        check("retain now", 16'(eeprom_retain_now), 16'h1);
        check("held", 16'(settings), e);
        n = erase_cnt;
        wr_op(CMD_CHIP_ERASE, BSEL_LOW, 8'hFF, busy);
        check("kept eeprom", 16'(erase_cnt - n), 16'h0);
        rd_chk("fuse high", CMD_RD_FUSE, BSEL_FHIGH, 8'h91);
        prog_mode <= 1'b0;
        repeat (4) @(posedge clk);
        check("applied", 16'(settings), exp_set(8'h91, 8'hE2));
        prog_mode <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_serial_lock();
        logic busy;
        serial_mode <= 1'b1;
        wr_op(CMD_WR_FUSE, BSEL_HIGH, 8'hB1, busy);
        rd_chk("serial fuse", CMD_RD_FUSE, BSEL_FHIGH, 8'h91);
        serial_mode <= 1'b0;
        wr_op(CMD_WR_LOCK, BSEL_LOW, 8'hFE, busy);
        rd_chk("lock set", CMD_RD_FUSE, BSEL_HIGH, 8'hFE);
        wr_op(CMD_WR_FUSE, BSEL_LOW, 8'h62, busy);
        rd_chk("locked fuse", CMD_RD_FUSE, BSEL_LOW, 8'hE2);
        prog.load(ACT_ADDR, BSEL_LOW, 8'h01);
        rd_chk("locked sig", CMD_RD_SIG, BSEL_LOW, SIG1);
        wr_op(CMD_CHIP_ERASE, BSEL_LOW, 8'hFF, busy);
        rd_chk("lock cleared", CMD_RD_FUSE, BSEL_HIGH, LOCK_RST);
        rd_chk("fuse after", CMD_RD_FUSE, BSEL_FHIGH, 8'h91);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_defaults();
        prog_mode <= 1'b1;
        repeat (4) @(posedge clk);
        t_reads();
        t_signature();
        t_address();
        t_erase_fuses();
        t_serial_lock();
        conclude();
    end
endmodule
